// >>> design/hbra_pkg.sv
/*
 * hbra_pkg: constants and carrier types for the host bus register access
 * block. Assumes a 10 MHz system clock sampling the asynchronous bus.
 */
package hbra_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 100;
    // write setup time for the slow line parameter / transmit data targets
    localparam int unsigned SLOW_SETUP_NS   = 300;
    localparam int unsigned SLOW_SETUP_CYC  =
        (SLOW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  SLOW_CNT_INIT   = 3'(SLOW_SETUP_CYC);

    // register select codes from address bits 02..01
    localparam logic [1:0]  SEL_CSR         = 2'h0;
    localparam logic [1:0]  SEL_RECEIVE_BUFFER_REG        = 2'h1;
    localparam logic [1:0]  SEL_TCR         = 2'h2;
    localparam logic [1:0]  SEL_MSR         = 2'h3;

    // bit positions within the bus word
    localparam int unsigned ADDR_BYTE_BIT   = 0;
    localparam int unsigned ADDR_SEL_LO     = 1;
    localparam int unsigned ADDR_MATCH_LO   = 3;
    localparam int unsigned ADDR_MATCH_HI   = 12;

    localparam logic [9:0]  BASE_ADDR_RST   = 10'h000;

    typedef enum logic [2:0] {
        HBRA_IDLE  = 3'b000,
        HBRA_ADDR  = 3'b001,
        HBRA_WAIT  = 3'b011,
        HBRA_REPLY = 3'b010,
        HBRA_DONE  = 3'b110
    } hbra_state_t;

    // asynchronous bus strobes, all active high after inversion
    typedef struct packed {
        logic sync;
        logic din;
        logic dout;
        logic wtbt;
        logic bs7;
        logic init;
    } hbra_strobe_t;

    // per-register write load pulses
    typedef struct packed {
        logic [3:0] load_hi;
        logic [3:0] load_lo;
    } hbra_load_t;

endpackage : hbra_pkg

// >>> design/hbra_top.sv
/*
 * hbra_top: bus-slave I/O control between the host's multiplexed async
 * address/data bus and the device registers: address latch, byte select,
 * read mux and transceiver control, reply timing, vector reply, init.
 * Assumes active-low bus pins are inverted outside and that register
 * contents, the vector request and the master clear bit come from
 * neighbouring logic on the same clock.
 */
// Functional notes
// - only address bits 00..02 pick the register and byte
// - reads are whole words; writes are byte or word
// - bits 02..01 select one of four registers and steer read mux
// - sync leading edge latches device match and address bits 00..02
// - word write selects both bytes; byte write uses address bit 00
// - load pulses only while data-out is asserted
// - transceiver direction from two read controls; outbound alone never
// - data-in in selected cycle drives read controls then reply
// - reply drops when host negates data-in
// - sync negated releases selects and read controls
// - slow register writes delay reply for 300 ns setup
// - host drops data-out after reply; device then drops reply
// - sync negated at write end drops register and byte selects
// - vector request answers with reply without sync or match
// - init out both polarities from bus init or master clear
// - device match needs bank select and address bits 03..12 equal base
`timescale 1ns/10ps
`default_nettype none

module hbra_top
    import hbra_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    input  wire hbra_strobe_t bus_strobe,
    input  wire logic [15:0]  bus_dal_in,
    input  wire logic [9:0]   base_addr,
    input  wire logic         slow_lpr_sel,
    input  wire logic [15:0]  reg_rd_data [4],
    input  wire logic         vector_request,
    input  wire logic         master_clear,
    output logic [15:0]       bus_dal_out,
    output logic              bus_dal_oe,
    output logic              bus_reply,
    output logic [1:0]        reg_select,
    output logic              high_byte_select,
    output logic              low_byte_select,
    output hbra_load_t        load,
    output logic              lpr_load,
    output logic              tdr_load,
    output logic              read_path_enable,
    output logic              transceiver_outbound,
    output logic [15:0]       int_data,
    output logic              module_init,
    output logic              module_init_n
);

    ////////////////////////////////////////////////////////////////////////
    // strobe synchronisers: three stages, change accepted when 2 and 3 agree

    hbra_strobe_t s1_r;
    hbra_strobe_t s2_r;
    hbra_strobe_t s3_r;
    hbra_strobe_t stb_r;
    logic [15:0]  dal2_r;
    logic [15:0]  dal1_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            dal1_r <= 16'h0000;
            dal2_r <= 16'h0000;
        end
        else if (clk_en)
        begin
            s1_r   <= bus_strobe;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            dal1_r <= bus_dal_in;
            dal2_r <= dal1_r;
        end
    end

    // filtered strobe: per bit, update only when stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < $bits(hbra_strobe_t); gi++)
        begin : g_filt
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    stb_r[gi] <= 1'b0;
                else if (clk_en && (s2_r[gi] == s3_r[gi]))
                    stb_r[gi] <= s3_r[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // initialisation

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            module_init <= 1'b1;
        else if (clk_en)
            module_init <= stb_r.init | master_clear;
    end
    assign module_init_n = ~module_init;

    logic rst_int;
    assign rst_int = module_init;

    ////////////////////////////////////////////////////////////////////////
    // address latch on sync leading edge

    logic        sync_d_r;
    logic        match_r;
    logic [2:0]  addr_r;
    logic        match_now;

    // address is sampled two cycles ahead of the strobe path, which keeps it
    // aligned with the filtered sync edge while the host holds address time
    assign match_now = stb_r.bs7 &&
        (dal2_r[ADDR_MATCH_HI:ADDR_MATCH_LO] == base_addr);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_d_r <= 1'b0;
            match_r  <= 1'b0;
            addr_r   <= 3'h0;
        end
        else if (clk_en)
        begin
            sync_d_r <= stb_r.sync;
            if (rst_int || !stb_r.sync)
            begin
                match_r <= 1'b0;
                addr_r  <= 3'h0;
            end
            else if (!sync_d_r)
            begin
                match_r <= match_now;
                addr_r  <= dal2_r[2:0];
            end
        end
    end

    assign reg_select = addr_r[2:ADDR_SEL_LO];

    ////////////////////////////////////////////////////////////////////////
    // byte selects, load pulses

    logic wr_active;
    assign wr_active = match_r && stb_r.sync && stb_r.dout;

    always_comb
    begin
        high_byte_select = 1'b0;
        low_byte_select  = 1'b0;
        if (wr_active)
        begin
            if (!stb_r.wtbt)
            begin
                high_byte_select = 1'b1;
                low_byte_select  = 1'b1;
            end
            else
            begin
                high_byte_select = addr_r[ADDR_BYTE_BIT];
                low_byte_select  = ~addr_r[ADDR_BYTE_BIT];
            end
        end
    end

    logic load_done_r;

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_load
            assign load.load_hi[gi] = !load_done_r && high_byte_select &&
                (reg_select == 2'(gi));
            assign load.load_lo[gi] = !load_done_r && low_byte_select &&
                (reg_select == 2'(gi));
        end
    endgenerate

    // line parameters share the select code of receive buffer on write,
    // transmit data shares that of modem status
    assign lpr_load = |load.load_lo[SEL_RECEIVE_BUFFER_REG] | load.load_hi[SEL_RECEIVE_BUFFER_REG];
    assign tdr_load = |load.load_lo[SEL_MSR] | load.load_hi[SEL_MSR];

    ////////////////////////////////////////////////////////////////////////
    // reply sequencer

    hbra_state_t state_r;
    logic [2:0]  wait_cnt_r;
    logic        slow_tgt;

    assign slow_tgt = (reg_select == SEL_RECEIVE_BUFFER_REG) ||
        (reg_select == SEL_MSR);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r     <= HBRA_IDLE;
            wait_cnt_r  <= 3'h0;
            load_done_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rst_int)
            begin
                state_r     <= HBRA_IDLE;
                load_done_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    HBRA_IDLE:
                        if (match_r && stb_r.din)
                            state_r <= HBRA_REPLY;
                        else if (wr_active)
                        begin
                            wait_cnt_r <= SLOW_CNT_INIT;
                            state_r    <= slow_tgt ? HBRA_WAIT
                                                   : HBRA_ADDR;
                        end
                    HBRA_ADDR:
                    begin
                        load_done_r <= 1'b1;
                        state_r     <= HBRA_REPLY;
                    end
                    HBRA_WAIT:
                        if (wait_cnt_r <= 3'h1)
                        begin
                            load_done_r <= 1'b1;
                            state_r     <= HBRA_REPLY;
                        end
                        else
                            wait_cnt_r <= wait_cnt_r - 3'h1;
                    HBRA_REPLY:
                        if (!stb_r.din && !stb_r.dout)
                            state_r <= HBRA_DONE;
                    HBRA_DONE:
                        if (!stb_r.sync)
                        begin
                            load_done_r <= 1'b0;
                            state_r     <= HBRA_IDLE;
                        end
                    default:
                        state_r <= HBRA_IDLE;
                endcase
            end
        end
    end

    assign bus_reply = (state_r == HBRA_REPLY) || vector_request;

    ////////////////////////////////////////////////////////////////////////
    // read path and transceivers

    logic rd_active;
    assign rd_active = match_r && stb_r.sync && stb_r.din &&
        (state_r == HBRA_REPLY || state_r == HBRA_IDLE);

    // both controls rise and fall together so outbound alone cannot occur
    assign read_path_enable     = rd_active;
    assign transceiver_outbound = rd_active;
    assign bus_dal_oe           = rd_active;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_dal_out <= 16'h0000;
            int_data    <= 16'h0000;
        end
        else if (clk_en)
        begin
            bus_dal_out <= reg_rd_data[reg_select];
            int_data    <= dal2_r;
        end
    end

endmodule // hbra_top

`default_nettype wire

// >>> testbench/hbra_sva.sv
/* hbra_sva: port assertions for hbra_top.
   assumes one clock domain and strobes as seen at the pins. */
`timescale 1ns/10ps
`default_nettype none
module hbra_sva
    import hbra_pkg::*;
(
    input wire logic         clk,
    input wire logic         nrst,
    input wire hbra_strobe_t bus_strobe,
    input wire logic         vector_request,
    input wire logic         master_clear,
    input wire logic         bus_reply,
    input wire logic [1:0]   reg_select,
    input wire logic         high_byte_select,
    input wire logic         low_byte_select,
    input wire hbra_load_t   load,
    input wire logic         lpr_load,
    input wire logic         tdr_load,
    input wire logic         read_path_enable,
    input wire logic         transceiver_outbound,
    input wire logic         module_init,
    input wire logic         module_init_n
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire logic slow_ld = lpr_load | tdr_load;
    wire logic sel_any = |reg_select | high_byte_select | low_byte_select;
    sequence data_end_s;
        ($fell(bus_strobe.din) || $fell(bus_strobe.dout)) && !vector_request;
    endsequence
    sequence slow_reply_s;
        $rose(bus_reply) && $past(bus_strobe.dout) && reg_select[0];
    endsequence
    reply_end_a:
        assert property (data_end_s |-> ##[1:8] !bus_reply) else $error("reply");
    sel_free_a:
        assert property ($fell(bus_strobe.sync) |-> ##[1:8]
            !(sel_any || read_path_enable)) else $error("selects held");
    read_drive_a:
        assert property ($rose(bus_reply) && $past(bus_strobe.din) &&
            !vector_request |-> $past(read_path_enable && transceiver_outbound))
            else $error("read");
    hi_load_a:
        assert property ((|load.load_hi) |->
            high_byte_select && load.load_hi == 4'h1 << reg_select)
            else $error("load select");
    word_sel_a:
        assert property ((|load) && !bus_strobe.wtbt |->
            high_byte_select && low_byte_select) else $error("word select");
    slow_setup_a:
        assert property (slow_reply_s |-> $past(slow_ld, 3) &&
            $past(slow_ld, 2) && $past(slow_ld)) else $error("setup");
    vec_reply_a:
        assert property (vector_request |-> bus_reply) else $error("vector");
    init_out_a:
        assert property ((bus_strobe.init || master_clear) |-> ##[1:6]
            (module_init && !module_init_n)) else $error("init");
endmodule // hbra_sva
bind hbra_top hbra_sva i_sva (.clk, .nrst, .bus_strobe, .vector_request,
    .master_clear, .bus_reply, .reg_select, .high_byte_select,
    .low_byte_select, .load, .lpr_load, .tdr_load, .read_path_enable,
    .transceiver_outbound, .module_init, .module_init_n);
`default_nettype wire

// >>> testbench/hbra_host.sv
/* hbra_host: host side of the async bus, one strobe cycle per call.
   assumes calls start at a falling clock edge. */
`timescale 1ns/10ps
`default_nettype none
module hbra_host
    import hbra_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        bus_reply,
    input  wire logic [15:0] bus_dal_out,
    output hbra_strobe_t     bus_strobe,
    output logic [15:0]      bus_dal_in
);
    initial
    begin
        bus_strobe = '0;
        bus_dal_in = 16'h5A5A;
    end
    // lat is -1 when no reply came; released lines show the inverse
    task automatic xfer(input logic wr, input logic byt, input logic [15:0] adr,
        input logic [15:0] wd, output logic [15:0] rd, output int lat);
        lat = -1;
        bus_dal_in = adr;
        bus_strobe.bs7 = 1'b1;
        bus_strobe.wtbt = wr;
        repeat (5) @(negedge clk);
        bus_strobe.sync = 1'b1;
        repeat (3) @(negedge clk);
        bus_strobe.bs7 = 1'b0;
        bus_strobe.wtbt = wr & byt;
        bus_dal_in = wr ? wd : ~adr;
        bus_strobe.dout = wr;
        bus_strobe.din = !wr;
        for (int i = 0; i < 30 && lat < 0; i++)
        begin
            @(negedge clk);
            if (bus_reply === 1'b1)
                lat = i;
        end
        rd = bus_dal_out;
        bus_dal_in = ~bus_dal_in;
        bus_strobe.din = 1'b0;
        bus_strobe.dout = 1'b0;
        for (int i = 0; i < 20 && bus_reply !== 1'b0; i++)
            @(negedge clk);
        bus_strobe.sync = 1'b0;
        bus_strobe.wtbt = 1'b0;
        repeat (6) @(negedge clk);
    endtask
endmodule // hbra_host
`default_nettype wire

// >>> testbench/testbench.sv
/* testbench: drives hbra_top through the host model and judges its ports.
   assumes the checker binds itself to hbra_top. */
`timescale 1ns/10ps
`default_nettype none
module testbench import hbra_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, arm = 1'b0, clk_en = 1'b1;
    logic vector_request = 1'b0, master_clear = 1'b0, bus_init = 1'b0;
    logic [9:0] seen = '0, base_addr = 10'h2A5;
    logic [15:0] reg_rd_data [4], rd, bus_dal_in, bus_dal_out;
    logic [15:0] int_data, wdat = 16'h0000;
    logic [2:0] rdc = '0;
    logic [1:0] reg_select;
    logic bus_dal_oe, bus_reply, high_byte_select, low_byte_select, lpr_load;
    logic tdr_load, read_path_enable, transceiver_outbound, module_init;
    logic module_init_n;
    hbra_strobe_t host_strobe, bus_strobe;
    hbra_load_t load;
    int errors = 0, total_checks = 0, lat, lat_f, lat_s;
    assign bus_strobe = host_strobe | {5'h0, bus_init};
    always #50 clk = ~clk;
    // sticky record of loads, read controls and inbound data while armed
    always @(posedge clk)
    begin
        if (arm)
        begin
            seen <= seen | {tdr_load, lpr_load, load};
            rdc  <= rdc | {read_path_enable, transceiver_outbound, bus_dal_oe};
        end
        if (arm && |load)
            wdat <= int_data;
    end
    hbra_top i_dut (.clk, .nrst, .clk_en, .bus_strobe, .bus_dal_in,
        .base_addr, .slow_lpr_sel(1'b0), .reg_rd_data, .vector_request,
        .master_clear, .bus_dal_out, .bus_dal_oe, .bus_reply, .reg_select,
        .high_byte_select, .low_byte_select, .load, .lpr_load, .tdr_load,
        .read_path_enable, .transceiver_outbound, .int_data,
        .module_init, .module_init_n);
    hbra_host i_host (.clk, .bus_reply, .bus_dal_out,
        .bus_strobe(host_strobe), .bus_dal_in);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] adr(input logic [1:0] s, input logic b0);
        return {3'h5, base_addr, s, b0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // address bit 0 set on reads: it must not move the selection
    task automatic t_read();
        for (int s = 0; s < 4; s++)
        begin
            seen = '0;
            rdc = '0;
            arm = 1'b1;
            i_host.xfer(1'b0, 1'b0, adr(2'(s), 1'b1), 16'h0, rd, lat);
            arm = 1'b0;
            chk(rd, reg_rd_data[s]);
            chk(16'(rdc), 16'h0007);
            chk(16'(seen), 16'h0000);
            chk(16'({reg_select, read_path_enable, bus_dal_oe, bus_reply}),
                16'h0000);
        end
        $display("read test done");
    endtask
    task automatic t_write();
        logic [3:0] hot;
        for (int k = 0; k < 3; k++)
            for (int s = 0; s < 4; s++)
            begin
                hot = 4'h1 << s;
                seen = '0;
                rdc = '0;
                wdat = 16'h0000;
                arm = 1'b1;
                i_host.xfer(1'b1, k != 0, adr(2'(s), k == 2), 16'hC3C3, rd, lat);
                arm = 1'b0;
                chk(16'(rdc), 16'h0000);
                chk(wdat, 16'hC3C3);
                chk(seen, {s == 3, s == 1, k == 1 ? 4'h0 : hot,
                    k == 2 ? 4'h0 : hot});
                chk(16'(lat >= 0), 16'h1);
                lat_f = (k == 0 && s == 0) ? lat : lat_f;
                lat_s = (k == 0 && s == 1) ? lat : lat_s;
            end
        chk(16'(lat_s >= lat_f + 2), 16'h1);
        $display("write test done");
    endtask
    task automatic t_other();
        i_host.xfer(1'b0, 1'b0, {3'h5, ~base_addr, 3'h0}, 16'h0, rd, lat);
        chk(16'(lat), 16'hFFFF);
        vector_request = 1'b1;
        @(negedge clk);
        chk(16'(bus_reply), 16'h1);
        vector_request = 1'b0;
        // a low clock enable must hold the init output where it stands
        clk_en = 1'b0;
        master_clear = 1'b1;
        repeat (3) @(negedge clk);
        chk({module_init, module_init_n}, 16'h1);
        clk_en = 1'b1;
        repeat (2) @(negedge clk);
        chk({module_init, module_init_n}, 16'h2);
        master_clear = 1'b0;
        repeat (2) @(negedge clk);
        for (int m = 0; m < 2; m++)
        begin
            master_clear = m == 0;
            bus_init = m == 1;
            repeat (6) @(negedge clk);
            chk({module_init, module_init_n}, 16'h2);
            master_clear = 1'b0;
            bus_init = 1'b0;
            repeat (6) @(negedge clk);
            chk({module_init, module_init_n}, 16'h1);
        end
        $display("match, vector and init test done");
    endtask
    initial
    begin
        for (int i = 0; i < 4; i++)
            reg_rd_data[i] = 16'hA50F ^ 16'(i * 16'h1111);
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_read();
        t_write();
        t_other();
        conclude();
    end
    initial
    begin
        #1000000;
        errors++;
        conclude();
    end
endmodule // testbench
`default_nettype wire
